// ===== hw/hpp_pkg.sv
// Purpose: constants for hub port power and over-current logic
// Assumes: 100 MHz clock, four downstream ports
// Notes: times kept in their own unit, counts derived from them
package hpp_pkg;
	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned NUM_PORTS = 4;
	// Over-current filter windows
	localparam int unsigned OCS_SINGLE_MS = 1;
	localparam int unsigned OCS_DOUBLE_MS = 20;
	localparam int unsigned OCS_SINGLE_CYC = OCS_SINGLE_MS * 1000 * CLK_MHZ;
	localparam int unsigned OCS_DOUBLE_CYC = OCS_DOUBLE_MS * 1000 * CLK_MHZ;
	// Link power state latencies
	localparam int unsigned L1_ENTRY_US = 10;
	localparam int unsigned L1_EXIT_US = 50;
	localparam int unsigned L2_ENTRY_MS = 3;
	localparam int unsigned L2_EXIT_MS = 2;
	localparam int unsigned L1_ENTRY_CYC = L1_ENTRY_US * CLK_MHZ - 1;
	localparam int unsigned L1_EXIT_CYC = L1_EXIT_US * CLK_MHZ - 1;
	localparam int unsigned L2_ENTRY_CYC = L2_ENTRY_MS * 1000 * CLK_MHZ;
	localparam int unsigned L2_EXIT_CYC = L2_EXIT_MS * 1000 * CLK_MHZ;
	// Header packet turnaround and old value
	localparam int unsigned HP_OLD_US = 3;
	localparam int unsigned HP_US = 10;
	localparam int unsigned HP_CYC = HP_US * CLK_MHZ;
	localparam int unsigned TMR_W = 24;
	localparam logic [1:0] MODE_COMBINED = 2'h0;
	localparam logic [1:0] MODE_GANGED = 2'h1;
	typedef enum logic [2:0] {
		HPP_L0, HPP_L1_ENTER, HPP_L1, HPP_L1_EXIT,
		HPP_L2_ENTER, HPP_L2, HPP_L2_EXIT
	} hpp_lpm_t;
endpackage

// ===== hw/hpp_ocs_filter.sv
// Purpose: per-pin over-current filter, single and double low pulse
// Assumes: sense input already synchronised to clk
// Notes: counters idle while the pin is not powered
`timescale 1ns/1ps
`default_nettype none
module hpp_ocs_filter #(
	parameter int unsigned SINGLE_CYC = 100000,
	parameter int unsigned DOUBLE_CYC = 2000000
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic enabled,
	input wire logic sense_low,
	output logic fault
);
	logic [hpp_pkg::TMR_W-1:0] low_cnt, next_low_cnt;
	logic [hpp_pkg::TMR_W-1:0] win_cnt, next_win_cnt;
	logic in_win, next_in_win;
	logic prev_low, next_prev_low;
	logic next_fault;

	// Low run length and rolling window; short isolated dips are ignored
	always_comb begin
		next_low_cnt = low_cnt;
		next_win_cnt = win_cnt;
		next_in_win = in_win;
		next_prev_low = sense_low & enabled;
		next_fault = 1'b0;
		if (!enabled) begin
			next_low_cnt = '0;
			next_win_cnt = '0;
			next_in_win = 1'b0;
		end else begin
			next_low_cnt = sense_low ? low_cnt + 1'b1 : '0;
			if (sense_low && low_cnt == hpp_pkg::TMR_W'(SINGLE_CYC - 1))
				next_fault = 1'b1;
			if (in_win) begin
				next_win_cnt = win_cnt + 1'b1;
				if (win_cnt == hpp_pkg::TMR_W'(DOUBLE_CYC - 1))
					next_in_win = 1'b0;
			end
			if (sense_low && !prev_low) begin
				if (in_win)
					next_fault = 1'b1;
				next_in_win = ~in_win;
				next_win_cnt = '0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			low_cnt <= '0;
			win_cnt <= '0;
			in_win <= 1'b0;
			prev_low <= 1'b0;
			fault <= 1'b0;
		end else begin
			low_cnt <= next_low_cnt;
			win_cnt <= next_win_cnt;
			in_win <= next_in_win;
			prev_low <= next_prev_low;
			fault <= next_fault;
		end
	end
endmodule
`default_nettype wire

// ===== hw/hpp_port_power.sv
// Purpose: downstream port power pins, over-current, link power states
// Assumes: pin pads resolve oe/out; pull-up enable drives pad pull-up
// Notes: ganged mode uses pin 0 as the shared pin
`timescale 1ns/1ps
`default_nettype none
module hpp_port_power #(
	parameter int unsigned OCS_SINGLE = hpp_pkg::OCS_SINGLE_CYC,
	parameter int unsigned OCS_DOUBLE = hpp_pkg::OCS_DOUBLE_CYC,
	parameter int unsigned L2_ENTRY = hpp_pkg::L2_ENTRY_CYC,
	parameter int unsigned L2_EXIT = hpp_pkg::L2_EXIT_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [1:0] port_mode,
	input wire logic [3:0] port_power_req,
	input wire logic [3:0] ocs_clear,
	input wire logic [3:0] port_power_sense_pin_in,
	output logic [3:0] port_power_sense_pin_out,
	output logic [3:0] port_power_sense_pin_oe,
	output logic [3:0] port_pullup_en,
	output logic [3:0] port_ocs_status,
	output logic [3:0] port_powered,
	input wire logic l1_req,
	input wire logic l2_req,
	input wire logic resume_req,
	output logic [2:0] lpm_state,
	output logic lpm_busy,
	input wire logic hp_start,
	input wire logic hp_ack,
	output logic hp_timeout,
	input wire logic lp_initiate,
	input wire logic lp_accept,
	input wire logic ux_exit,
	output logic [1:0] pm_timer_sel,
	input wire logic [3:0] ss_connected,
	input wire logic [3:0] ss_suspended,
	input wire logic [3:0] ss_remote_wake_en,
	input wire logic [3:0] ss_conn_change,
	output logic remote_wake
);
	localparam int unsigned NP = hpp_pkg::NUM_PORTS;
	logic [3:0] sync1, sync2;
	logic [3:0] fault, ocs, next_ocs, powered, next_powered;
	logic [3:0] next_out, next_oe, next_pu;
	logic [3:0] sense_low, filt_en;
	logic [3:0] up1, up2;
	logic next_busy;
	hpp_pkg::hpp_lpm_t lpm, next_lpm;
	logic [hpp_pkg::TMR_W-1:0] lpm_cnt, next_lpm_cnt;
	logic [hpp_pkg::TMR_W-1:0] hp_cnt, next_hp_cnt;
	logic hp_run, next_hp_run, next_hp_timeout;
	logic [1:0] next_sel;
	logic next_wake;
	logic ganged;

	assign ganged = (port_mode == hpp_pkg::MODE_GANGED);

	// Pin synchroniser; first stage feeds only the second
	// Power-up delay line matches the synchroniser latency
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1 <= 4'hf;
			sync2 <= 4'hf;
			up1 <= 4'h0;
			up2 <= 4'h0;
		end else begin
			sync1 <= port_power_sense_pin_in;
			sync2 <= sync1;
			up1 <= powered;
			up2 <= up1;
		end
	end

	// masked until power has been on for two cycles; ganged mode masks pins 1-3 always
	always_comb begin
		sense_low = ~sync2;
		filt_en = powered & up2;
		if (ganged) begin
			filt_en = {3'h0, powered[0] & up2[0]};
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NP; gi++) begin : g_flt
			hpp_ocs_filter #(
				.SINGLE_CYC(OCS_SINGLE),
				.DOUBLE_CYC(OCS_DOUBLE)
			) u_flt (
				.clk(clk),
				.rst_n(rst_n),
				.enabled(filt_en[gi]),
				.sense_low(sense_low[gi]),
				.fault(fault[gi])
			);
		end
	endgenerate

	// Power, latch and pin drive; same pin scheme for switch or fuse
	always_comb begin
		next_ocs = ocs;
		next_powered = powered;
		for (int i = 0; i < NP; i++) begin
			if (ocs_clear[i])
				next_ocs[i] = 1'b0;
			if (ganged ? fault[0] : fault[i])
				next_ocs[i] = 1'b1;
		end
		if (ganged)
			next_powered = {4{port_power_req[0] & ~next_ocs[0]}};
		else
			next_powered = port_power_req & ~next_ocs;
		next_out = 4'h0;
		next_oe = ~next_powered;
		next_pu = next_powered;
		if (ganged) begin
			next_oe[3:1] = 3'h0;
			next_pu[3:1] = 3'h0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ocs <= 4'h0;
			powered <= 4'h0;
			port_power_sense_pin_out <= 4'h0;
			port_power_sense_pin_oe <= 4'hf;
			port_pullup_en <= 4'h0;
		end else begin
			ocs <= next_ocs;
			powered <= next_powered;
			port_power_sense_pin_out <= next_out;
			port_power_sense_pin_oe <= next_oe;
			port_pullup_en <= next_pu;
		end
	end
	assign port_ocs_status = ocs;
	assign port_powered = powered;

	always_comb begin
		next_lpm = lpm;
		next_lpm_cnt = lpm_cnt + 1'b1;
		unique case (lpm)
			hpp_pkg::HPP_L0: begin
				next_lpm_cnt = '0;
				if (l2_req)
					next_lpm = hpp_pkg::HPP_L2_ENTER;
				else if (l1_req)
					next_lpm = hpp_pkg::HPP_L1_ENTER;
			end
			hpp_pkg::HPP_L1_ENTER: begin
				if (lpm_cnt == hpp_pkg::TMR_W'(hpp_pkg::L1_ENTRY_CYC - 1))
					next_lpm = hpp_pkg::HPP_L1;
			end
			hpp_pkg::HPP_L1: begin
				next_lpm_cnt = '0;
				if (resume_req)
					next_lpm = hpp_pkg::HPP_L1_EXIT;
			end
			hpp_pkg::HPP_L1_EXIT: begin
				if (lpm_cnt == hpp_pkg::TMR_W'(hpp_pkg::L1_EXIT_CYC - 1))
					next_lpm = hpp_pkg::HPP_L0;
			end
			hpp_pkg::HPP_L2_ENTER: begin
				if (lpm_cnt == hpp_pkg::TMR_W'(L2_ENTRY - 1))
					next_lpm = hpp_pkg::HPP_L2;
			end
			hpp_pkg::HPP_L2: begin
				next_lpm_cnt = '0;
				if (resume_req)
					next_lpm = hpp_pkg::HPP_L2_EXIT;
			end
			hpp_pkg::HPP_L2_EXIT: begin
				if (lpm_cnt == hpp_pkg::TMR_W'(L2_EXIT - 1))
					next_lpm = hpp_pkg::HPP_L0;
			end
			default: begin
				next_lpm = hpp_pkg::HPP_L0;
				next_lpm_cnt = '0;
			end
		endcase
		// Busy only in the timed transition states
		next_busy = (next_lpm != hpp_pkg::HPP_L0) &&
			(next_lpm != hpp_pkg::HPP_L1) && (next_lpm != hpp_pkg::HPP_L2);
	end

	// Header ack turnaround, timer select, remote wake
	always_comb begin
		next_hp_run = hp_run;
		next_hp_cnt = hp_cnt;
		next_hp_timeout = 1'b0;
		if (hp_start) begin
			next_hp_run = 1'b1;
			next_hp_cnt = '0;
		end else if (hp_run) begin
			next_hp_cnt = hp_cnt + 1'b1;
			if (hp_ack) begin
				next_hp_run = 1'b0;
			end else if (hp_cnt == hpp_pkg::TMR_W'(hpp_pkg::HP_CYC - 1)) begin
				next_hp_run = 1'b0;
				next_hp_timeout = 1'b1;
			end
		end
		if (lp_initiate)
			next_sel = 2'h1;
		else if (lp_accept)
			next_sel = 2'h2;
		else if (ux_exit)
			next_sel = 2'h3;
		else
			next_sel = 2'h0;
		next_wake = |(ss_connected & ss_suspended & ss_remote_wake_en &
			ss_conn_change);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lpm <= hpp_pkg::HPP_L0;
			lpm_cnt <= '0;
			hp_run <= 1'b0;
			hp_cnt <= '0;
			hp_timeout <= 1'b0;
			pm_timer_sel <= 2'h0;
			remote_wake <= 1'b0;
			lpm_busy <= 1'b0;
		end else begin
			lpm <= next_lpm;
			lpm_cnt <= next_lpm_cnt;
			hp_run <= next_hp_run;
			hp_cnt <= next_hp_cnt;
			hp_timeout <= next_hp_timeout;
			pm_timer_sel <= next_sel;
			remote_wake <= next_wake;
			lpm_busy <= next_busy;
		end
	end
	assign lpm_state = lpm;
endmodule
`default_nettype wire

// ===== testbench/hpp_switch_model.sv
// Purpose: power switch or fuse model on the port pins
// Assumes: fault input stands for a tripped switch or blown fuse
// Notes: an undriven, unpulled pin toggles rather than holding
`timescale 1ns/1ps
`default_nettype none
module hpp_switch_model (
	input wire logic clk,
	input wire logic [3:0] oe,
	input wire logic [3:0] out,
	input wire logic [3:0] pull_en,
	input wire logic [3:0] fault,
	output logic [3:0] pin
);
	// fuse setup: power good at once
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			pin[i] = oe[i] ? out[i] : (fault[i] ? 1'b0 : (pull_en[i] | clk));
		end
	end
endmodule
`default_nettype wire

// ===== testbench/hpp_port_power_assertions.sv
// Purpose: port power checker
// Assumes: bound to the port power top
// Notes: port 1 stands for the combined ports
`timescale 1ns/1ps
`default_nettype none
module hpp_port_power_assertions (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [1:0] port_mode,
	input wire logic [3:0] port_power_req,
	input wire logic [3:0] ocs_clear,
	input wire logic [3:0] port_power_sense_pin_out,
	input wire logic [3:0] port_power_sense_pin_oe,
	input wire logic [3:0] port_pullup_en,
	input wire logic [3:0] port_ocs_status,
	input wire logic l1_req,
	input wire logic l2_req,
	input wire logic [2:0] lpm_state,
	input wire logic lp_initiate,
	input wire logic [1:0] pm_timer_sel,
	input wire logic [3:0] ss_connected,
	input wire logic [3:0] ss_suspended,
	input wire logic [3:0] ss_remote_wake_en,
	input wire logic [3:0] ss_conn_change,
	input wire logic remote_wake
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic [3:0] wake_src;
	// Ports that owe the host a wake
	assign wake_src = ss_connected & ss_suspended & ss_remote_wake_en
		& ss_conn_change;
	// Pin driver only ever pulls low
	low_only_a: assert property (port_power_sense_pin_out == 4'h0)
		else $error("pin driven high");
	no_fight_a: assert property ((port_power_sense_pin_oe & port_pullup_en) == 4'h0)
		else $error("driver and pull-up both on");
	power_on_a: assert property ($rose(port_power_req[1])
		&& port_mode == hpp_pkg::MODE_COMBINED && port_ocs_status == 4'h0
		|=> !port_power_sense_pin_oe[1] && port_pullup_en[1])
		else $error("port power not opened");
	fault_off_a: assert property ($rose(port_ocs_status[1])
		|=> port_power_sense_pin_oe[1] && !port_pullup_en[1])
		else $error("faulted port still powered");
	fault_held_a: assert property (port_ocs_status[1] && !ocs_clear[1]
		|=> port_ocs_status[1]) else $error("fault not held");
	ganged_pins_a: assert property (port_mode == hpp_pkg::MODE_GANGED [*2]
		|-> port_power_sense_pin_oe[3:1] == 3'h0 && port_pullup_en[3:1] == 3'h0)
		else $error("extra pins used in ganged mode");
	sleep_go_a: assert property (lpm_state == hpp_pkg::HPP_L0 && l1_req
		&& !l2_req |=> lpm_state == hpp_pkg::HPP_L1_ENTER)
		else $error("sleep request ignored");
	sleep_time_a: assert property ($rose(lpm_state == hpp_pkg::HPP_L1_ENTER)
		|-> ##[1:999] lpm_state == hpp_pkg::HPP_L1) else $error("sleep entry slow");
	timer_pick_a: assert property (lp_initiate |=> pm_timer_sel == 2'h1)
		else $error("wrong timer chosen");
	wake_follow_a: assert property (1'b1 |=> remote_wake == |$past(wake_src))
		else $error("remote wake mismatch");
	cover property ($rose(port_ocs_status[1]));
	cover property (lpm_state == hpp_pkg::HPP_L2);
	cover property (remote_wake);
endmodule
bind hpp_port_power hpp_port_power_assertions chk (.clk(clk), .rst_n(rst_n),
	.port_mode(port_mode), .port_power_req(port_power_req),
	.ocs_clear(ocs_clear), .port_power_sense_pin_out(port_power_sense_pin_out),
	.port_power_sense_pin_oe(port_power_sense_pin_oe),
	.port_pullup_en(port_pullup_en), .port_ocs_status(port_ocs_status),
	.l1_req(l1_req), .l2_req(l2_req), .lpm_state(lpm_state),
	.lp_initiate(lp_initiate), .pm_timer_sel(pm_timer_sel),
	.ss_connected(ss_connected), .ss_suspended(ss_suspended),
	.ss_remote_wake_en(ss_remote_wake_en), .ss_conn_change(ss_conn_change),
	.remote_wake(remote_wake));
`default_nettype wire

// ===== testbench/hpp_port_power_tb_top.sv
// Purpose: bench for port power, over-current and link states
// Assumes: filter 8/40 cycles, suspend counts 10
// Notes: a switch model drives the pins
`timescale 1ns/1ps
`default_nettype none
module hpp_port_power_tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [1:0] mode = 2'h0;
	logic [1:0] tsel;
	logic l1 = 1'b0, l2 = 1'b0, rs = 1'b0, hs = 1'b0, ha = 1'b0, hto, rw;
	logic li = 1'b0, la = 1'b0, ux = 1'b0;
	logic [3:0] req = 4'h0, clr = 4'h0, fault = 4'h0;
	logic [3:0] sc = 4'h0, ss = 4'h0, sw = 4'h0, sx = 4'h0;
	logic [3:0] pin, pout, oe, pu, st;
	logic [2:0] ls;
	logic [3:0] pw;
	logic busy;
	int n_errors = 0, checks = 0, cyc = 0, n = 0;
	hpp_port_power #(.OCS_SINGLE(8), .OCS_DOUBLE(40), .L2_ENTRY(10),
		.L2_EXIT(10)) uut (.clk(clk), .rst_n(rst_n), .port_mode(mode),
		.port_power_req(req), .ocs_clear(clr), .port_power_sense_pin_in(pin),
		.port_power_sense_pin_out(pout), .port_power_sense_pin_oe(oe),
		.port_pullup_en(pu), .port_ocs_status(st), .port_powered(pw),
		.l1_req(l1), .l2_req(l2), .resume_req(rs), .lpm_state(ls),
		.lpm_busy(busy), .hp_start(hs), .hp_ack(ha), .hp_timeout(hto),
		.lp_initiate(li), .lp_accept(la), .ux_exit(ux), .pm_timer_sel(tsel),
		.ss_connected(sc), .ss_suspended(ss), .ss_remote_wake_en(sw),
		.ss_conn_change(sx), .remote_wake(rw));
	hpp_switch_model sw_model (.clk(clk), .oe(oe), .out(pout), .pull_en(pu),
		.fault(fault), .pin(pin));
	// Free-running clock
	always #5 clk = ~clk;
	// Hang guard, tests need about 8700 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			n_errors++;
			conclude();
		end
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h, expected %h", $time, seen, exp);
		end
	endtask
	task tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	// Counts cycles to a link state, bounded
	task wait_ls(input logic [2:0] s);
		n = 0;
		while (ls !== s && n < 6000) begin
			tick(1);
			n++;
		end
	endtask
	task dip(input int k);
		fault[1] = 1'b1;
		tick(k);
		fault[1] = 1'b0;
	endtask
	task conclude;
		$display("errors %0d, checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Main sequence
	initial begin
		tick(4);
		rst_n = 1'b1;
		chk(oe, 4'hf);
		chk(pu, 4'h0);
		req = 4'h2;
		tick(1);
		chk(oe, 4'hd);
		chk(pu, 4'h2);
		chk(pw, 4'h2);
		fault[1] = 1'b1;
		tick(8);
		chk(st, 4'h0);
		tick(6);
		chk(st, 4'h2);
		chk(oe, 4'hf);
		fault[1] = 1'b0;
		tick(3);
		chk(pu, 4'h0);
		clr = 4'h2;
		tick(1);
		clr = 4'h0;
		tick(2);
		chk({st, oe}, 8'h0d);
		$display("single pulse test done");
		dip(3);
		tick(50);
		chk(st, 4'h0);
		dip(2);
		tick(5);
		dip(2);
		tick(6);
		chk(st, 4'h2);
		$display("double pulse test done");
		clr = 4'h2;
		req = 4'h0;
		mode = 2'h1;
		tick(1);
		clr = 4'h0;
		req = 4'h1;
		tick(2);
		chk({oe, pu}, 8'h01);
		chk(pw, 4'hf);
		$display("ganged test done");
		mode = 2'h0;
		l1 = 1'b1;
		tick(1);
		l1 = 1'b0;
		chk(ls, hpp_pkg::HPP_L1_ENTER);
		chk(busy, 1'b1);
		wait_ls(hpp_pkg::HPP_L1);
		chk(n < 1000, 1'b1);
		chk(busy, 1'b0);
		rs = 1'b1;
		tick(1);
		rs = 1'b0;
		wait_ls(hpp_pkg::HPP_L0);
		chk(n < 5000, 1'b1);
		l2 = 1'b1;
		tick(1);
		l2 = 1'b0;
		wait_ls(hpp_pkg::HPP_L2);
		chk(n >= 8 && n <= 11, 1'b1);
		rs = 1'b1;
		tick(1);
		rs = 1'b0;
		wait_ls(hpp_pkg::HPP_L0);
		chk(n >= 8 && n <= 11, 1'b1);
		$display("link state test done");
		hs = 1'b1;
		tick(1);
		hs = 1'b0;
		tick(500);
		ha = 1'b1;
		tick(1);
		ha = 1'b0;
		n = 0;
		repeat (1100) begin
			tick(1);
			n = n + (hto === 1'b1);
		end
		chk(n, 0);
		hs = 1'b1;
		tick(1);
		hs = 1'b0;
		n = 0;
		while (hto !== 1'b1 && n < 1100) begin
			tick(1);
			n++;
		end
		chk(n >= 900 && n <= 1001, 1'b1);
		$display("header timer test done");
		li = 1'b1;
		la = 1'b1;
		tick(1);
		chk(tsel, 2'h1);
		li = 1'b0;
		tick(1);
		chk(tsel, 2'h2);
		la = 1'b0;
		ux = 1'b1;
		tick(1);
		chk(tsel, 2'h3);
		ux = 1'b0;
		{sc, ss, sw, sx} = 16'h4444;
		tick(1);
		chk(rw, 1'b1);
		chk(tsel, 2'h0);
		sx = 4'h0;
		tick(1);
		chk(rw, 1'b0);
		$display("timer and wake test done");
		conclude();
	end
endmodule
`default_nettype wire
